//--- logic/timer_io_pkg.sv
/*
 * Shared constants for the preset interval timer I/O block: timing
 * figures, register offsets, field positions and mode encodings.
 * Assumes a 10 MHz core clock and a plain strobe register port.
 */
package timer_io_pkg;

	localparam int unsigned CLK_HZ = 10_000_000;

	// minimum accepted input widths, in microseconds
	localparam int unsigned WIDTH_SHORT_US = 1000;
	localparam int unsigned WIDTH_LONG_US = 20000;
	localparam int unsigned WIDTH_SHORT_CYC =
		(WIDTH_SHORT_US * (CLK_HZ / 1_000_000));
	localparam int unsigned WIDTH_LONG_CYC =
		(WIDTH_LONG_US * (CLK_HZ / 1_000_000));

	// one timing tick of the present value, in microseconds
	localparam int unsigned TICK_US = 1000;
	localparam int unsigned TICK_CYC = (TICK_US * (CLK_HZ / 1_000_000));

	// unit indicator flash half period, in microseconds
	localparam int unsigned FLASH_US = 500000;
	localparam int unsigned FLASH_CYC = (FLASH_US * (CLK_HZ / 1_000_000));

	localparam int unsigned CNT_W = 24;

	// register offsets
	localparam logic [3:0] REG_CONTROL = 4'h0;
	localparam logic [3:0] REG_SET_VALUE = 4'h1;
	localparam logic [3:0] REG_PRESENT = 4'h2;
	localparam logic [3:0] REG_STATUS = 4'h3;
	localparam logic [3:0] REG_EVENT = 4'h4;
	localparam logic [3:0] REG_MASK = 4'h5;

	// control fields
	localparam int unsigned CTL_MODE_LSB = 0;
	localparam int unsigned CTL_DOWN_BIT = 3;
	localparam int unsigned CTL_WIDTH_BIT = 4;
	localparam int unsigned CTL_LONG_UNIT_BIT = 5;
	localparam int unsigned CTL_KEY_BIT = 6;
	localparam logic [7:0] CTL_RESET = 8'h00;

	localparam logic [CNT_W-1:0] SET_RESET = 24'h0003E8;

	// event bits
	localparam int unsigned EV_UP = 0;
	localparam int unsigned EV_RESET = 1;
	localparam int unsigned EV_START = 2;
	localparam int unsigned EV_W = 3;

	typedef enum logic [2:0] {
		MODE_A = 3'b000,
		MODE_A2 = 3'b001,
		MODE_A3 = 3'b010,
		MODE_E = 3'b011,
		MODE_F = 3'b100,
		MODE_S = 3'b101
	} mode_t;

endpackage : timer_io_pkg

//--- logic/input_filter.sv
/*
 * Synchroniser and width filter for one contact input.
 * Assumes an asynchronous level input; the minimum width in cycles is
 * chosen by the caller and may change only between input edges.
 */
`timescale 1ns/1ps
module input_filter #(
	parameter int unsigned CW = 18
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic raw_i,
	input wire logic [CW-1:0] width_i,
	output logic level_o
);
	logic sync_a;
	logic sync_b;
	logic sync_c;
	logic [CW-1:0] stable;
	logic [CW-1:0] next_stable;
	logic level;
	logic next_level;

	always_comb begin
		next_stable = stable;
		next_level = level;
		// a change counts once second and third stages agree
		if (sync_b != sync_c || sync_c == level) begin
			next_stable = '0;
		end else if (stable + CW'(1) >= width_i) begin
			next_level = sync_c;
			next_stable = '0;
		end else begin
			next_stable = stable + CW'(1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync_a <= 1'b0;
			sync_b <= 1'b0;
			sync_c <= 1'b0;
			stable <= '0;
			level <= 1'b0;
		end else begin
			sync_a <= raw_i;
			sync_b <= sync_a;
			sync_c <= sync_b;
			stable <= next_stable;
			level <= next_level;
		end
	end

	assign level_o = level;
endmodule : input_filter

//--- logic/preset_interval_timer_io.sv
/*
 * Preset interval timer I/O core: filtered start, reset and gate
 * inputs, present value counter, control output, indicators, register
 * port and interrupt. Assumes 10 MHz clk_i and contact inputs that are
 * asynchronous and active high after level shifting.
 */
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module preset_interval_timer_io #(
	parameter int unsigned WIDTH_SHORT = timer_io_pkg::WIDTH_SHORT_CYC,
	parameter int unsigned WIDTH_LONG = timer_io_pkg::WIDTH_LONG_CYC,
	parameter int unsigned TICK = timer_io_pkg::TICK_CYC,
	parameter int unsigned FLASH = timer_io_pkg::FLASH_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic start_i,
	input wire logic reset_in_i,
	input wire logic gate_i,
	input wire logic reset_key_i,
	input wire logic [3:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	output logic control_out_o,
	output logic reset_led_o,
	output logic unit_led_o,
	output logic irq_o
);
	localparam int unsigned FW = 18;
	localparam int unsigned TW = 24;
	localparam int unsigned CW = timer_io_pkg::CNT_W;

	logic [7:0] control;
	logic [CW-1:0] set_value;
	logic [CW-1:0] present;
	logic [timer_io_pkg::EV_W-1:0] events;
	logic [timer_io_pkg::EV_W-1:0] mask;
	logic running;
	logic out_on;
	logic start_d;
	logic reset_d;
	logic [TW-1:0] tick_cnt;
	logic [TW-1:0] flash_cnt;
	logic flash_ph;
	logic [31:0] rdata;

	logic [7:0] next_control;
	logic [CW-1:0] next_set_value;
	logic [CW-1:0] next_present;
	logic [timer_io_pkg::EV_W-1:0] next_events;
	logic [timer_io_pkg::EV_W-1:0] next_mask;
	logic next_running;
	logic next_out_on;
	logic [TW-1:0] next_tick_cnt;
	logic [TW-1:0] next_flash_cnt;
	logic next_flash_ph;
	logic [31:0] next_rdata;

	logic start_lvl;
	logic reset_lvl;
	logic gate_lvl;
	logic key_lvl;
	logic [FW-1:0] width_sel;
	timer_io_pkg::mode_t mode;
	logic count_down;
	logic reset_any;
	logic start_rise;
	logic reset_rise;
	logic inhibit_mode;
	logic tick;
	logic reached;
	logic timing;
	logic [timer_io_pkg::EV_W-1:0] ev_set;

	assign mode = timer_io_pkg::mode_t'(control[timer_io_pkg::CTL_MODE_LSB +: 3]);
	assign count_down = control[timer_io_pkg::CTL_DOWN_BIT];
	// a longer width trades reset response for contact bounce immunity
	assign width_sel = control[timer_io_pkg::CTL_WIDTH_BIT] ?
		FW'(WIDTH_LONG) : FW'(WIDTH_SHORT);

	// one filter per input; all four share the selected width
	for (genvar i = 0; i < 4; i++) begin : g_in
		logic raw;
		logic lvl;
		assign raw = (i == 0) ? start_i : (i == 1) ? reset_in_i :
			(i == 2) ? gate_i : reset_key_i;
		input_filter #(
			.CW(FW)
		) u_filt (
			.clk_i(clk_i),
			.rst_i(rst_i),
			.raw_i(raw),
			.width_i(width_sel),
			.level_o(lvl)
		);
	end
	assign start_lvl = g_in[0].lvl;
	assign reset_lvl = g_in[1].lvl;
	assign gate_lvl = g_in[2].lvl;
	assign key_lvl = g_in[3].lvl & control[timer_io_pkg::CTL_KEY_BIT];

	assign reset_any = reset_lvl | key_lvl;
	assign start_rise = start_lvl & ~start_d;
	assign reset_rise = reset_any & ~reset_d;
	assign inhibit_mode = (mode == timer_io_pkg::MODE_A2) ||
		(mode == timer_io_pkg::MODE_A3);
	assign tick = (tick_cnt == TW'(TICK - 1));
	assign reached = count_down ? (present == '0) : (present >= set_value);
	assign timing = running & ~gate_lvl & ~reset_any &
		~(inhibit_mode & start_lvl) & ~reached;

	always_comb begin
		next_running = running;
		next_out_on = out_on;
		next_present = present;
		next_tick_cnt = timing ? (tick ? '0 : tick_cnt + TW'(1)) : tick_cnt;
		ev_set = '0;
		if (reset_any) begin
			// reset overrides gate and start
			next_present = count_down ? set_value : '0;
			next_out_on = 1'b0;
			next_tick_cnt = '0;
			next_running = inhibit_mode;
		end else begin
			unique case (mode)
			timer_io_pkg::MODE_A2, timer_io_pkg::MODE_A3: begin
				next_running = 1'b1;
			end
			timer_io_pkg::MODE_S: begin
				if (start_rise) begin
					next_running = ~running;
				end
			end
			timer_io_pkg::MODE_E: begin
				if (start_rise) begin
					next_running = 1'b1;
					next_present = count_down ? set_value : '0;
				end
			end
			default: begin
				if (start_rise) begin
					next_running = 1'b1;
				end
			end
			endcase
			if (timing && tick) begin
				next_present = count_down ? present - CW'(1) :
					present + CW'(1);
			end
			// interval mode: on while running, off at set value counting up or at zero counting down
			if (mode == timer_io_pkg::MODE_E) begin
				next_out_on = next_running & ~reached;
			end else if (reached) begin
				next_out_on = 1'b1;
			end
			if (next_out_on && !out_on) begin
				ev_set[timer_io_pkg::EV_UP] = 1'b1;
			end
			if (start_rise) begin
				ev_set[timer_io_pkg::EV_START] = 1'b1;
			end
		end
		if (reset_rise) begin
			ev_set[timer_io_pkg::EV_RESET] = 1'b1;
		end
	end

	always_comb begin
		next_flash_cnt = flash_cnt;
		next_flash_ph = flash_ph;
		if (!control[timer_io_pkg::CTL_LONG_UNIT_BIT] || !timing) begin
			next_flash_cnt = '0;
			next_flash_ph = 1'b1;
		end else if (flash_cnt == TW'(FLASH - 1)) begin
			next_flash_cnt = '0;
			next_flash_ph = ~flash_ph;
		end else begin
			next_flash_cnt = flash_cnt + TW'(1);
		end
	end

	always_comb begin
		next_control = control;
		next_set_value = set_value;
		next_mask = mask;
		next_events = events;
		next_rdata = '0;
		if (wr_i) begin
			unique case (addr_i)
			timer_io_pkg::REG_CONTROL: next_control = wdata_i[7:0];
			timer_io_pkg::REG_SET_VALUE: next_set_value = wdata_i[CW-1:0];
			timer_io_pkg::REG_EVENT:
				next_events = events & ~wdata_i[timer_io_pkg::EV_W-1:0];
			timer_io_pkg::REG_MASK:
				next_mask = wdata_i[timer_io_pkg::EV_W-1:0];
			default: ;
			endcase
		end
		// set wins over a clear in the same cycle
		next_events = next_events | ev_set;
		if (rd_i) begin
			unique case (addr_i)
			timer_io_pkg::REG_CONTROL: next_rdata = {24'h000000, control};
			timer_io_pkg::REG_SET_VALUE: next_rdata = {8'h00, set_value};
			timer_io_pkg::REG_PRESENT: next_rdata = {8'h00, present};
			timer_io_pkg::REG_STATUS:
				next_rdata = {28'h0000000, gate_lvl, reset_any, running,
					out_on};
			timer_io_pkg::REG_EVENT: next_rdata = {29'h0, events};
			timer_io_pkg::REG_MASK: next_rdata = {29'h0, mask};
			default: next_rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			control <= timer_io_pkg::CTL_RESET;
			set_value <= timer_io_pkg::SET_RESET;
			present <= '0;
			events <= '0;
			mask <= '0;
			running <= 1'b0;
			out_on <= 1'b0;
			start_d <= 1'b0;
			reset_d <= 1'b0;
			tick_cnt <= '0;
			flash_cnt <= '0;
			flash_ph <= 1'b1;
			rdata <= '0;
		end else begin
			control <= next_control;
			set_value <= next_set_value;
			present <= next_present;
			events <= next_events;
			mask <= next_mask;
			running <= next_running;
			out_on <= next_out_on;
			start_d <= start_lvl;
			reset_d <= reset_any;
			tick_cnt <= next_tick_cnt;
			flash_cnt <= next_flash_cnt;
			flash_ph <= next_flash_ph;
			rdata <= next_rdata;
		end
	end

	assign rdata_o = rdata;
	assign control_out_o = out_on;
	assign reset_led_o = reset_any;
	assign unit_led_o = flash_ph;
	assign irq_o = |(events & mask);
endmodule : preset_interval_timer_io

//--- test/timer_io_chk.sv
/* Port checker for the timer I/O core, bound to its top module.
   Assumes filter widths of at most WIDTH_LONG cycles. */
`timescale 1ns/1ps
module timer_io_chk #(
	parameter int unsigned WIDTH_LONG = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic reset_in_i,
	input wire logic reset_key_i,
	input wire logic rd_i,
	input wire logic [31:0] rdata_o,
	input wire logic control_out_o,
	input wire logic reset_led_o,
	input wire logic unit_led_o,
	input wire logic irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// sync flops plus filter width, with margin
	localparam logic [7:0] SETTLE = 8'(WIDTH_LONG + 8);
	logic [7:0] hi_cnt, next_hi_cnt, lo_cnt, next_lo_cnt;
	always_comb begin
		next_hi_cnt = reset_in_i ? hi_cnt + {7'h00, hi_cnt != 8'hFF} : 8'h00;
		next_lo_cnt = (reset_in_i || reset_key_i) ? 8'h00 :
			lo_cnt + {7'h00, lo_cnt != 8'hFF};
	end
	always_ff @(posedge clk_i) begin
		hi_cnt <= rst_i ? 8'h00 : next_hi_cnt;
		lo_cnt <= rst_i ? 8'h00 : next_lo_cnt;
	end
	out_after_rst_a: assert property ($fell(rst_i) |->
		!control_out_o && !irq_o && unit_led_o) else $error("bad state after reset");
	rdata_idle_a: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
		else $error("read data without read");
	reset_kills_out_a: assert property (reset_led_o |=> !control_out_o)
		else $error("output on during reset");
	out_rise_clean_a: assert property ($rose(control_out_o) |->
		!$past(reset_led_o)) else $error("output rose in reset");
	led_cause_a: assert property ($rose(reset_led_o) |->
		$past(reset_in_i || reset_key_i, 4)) else $error("led without input");
	led_held_a: assert property (hi_cnt >= SETTLE |-> reset_led_o)
		else $error("reset led dark");
	led_release_a: assert property (lo_cnt >= SETTLE |-> !reset_led_o)
		else $error("reset led stuck");
	out_off_held_a: assert property (hi_cnt >= SETTLE |-> !control_out_o)
		else $error("output slow to drop");
	unit_steady_a: assert property (hi_cnt >= SETTLE |-> unit_led_o)
		else $error("unit led flashing in reset");
	out_cov: cover property ($rose(control_out_o));
	led_cov: cover property ($rose(reset_led_o));
	flash_cov: cover property ($fell(unit_led_o));
endmodule : timer_io_chk
bind preset_interval_timer_io timer_io_chk #(.WIDTH_LONG(WIDTH_LONG)) u_chk (
	.clk_i(clk_i), .rst_i(rst_i), .reset_in_i(reset_in_i),
	.reset_key_i(reset_key_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.control_out_o(control_out_o), .reset_led_o(reset_led_o),
	.unit_led_o(unit_led_o), .irq_o(irq_o));

//--- test/contact_model.sv
/* Contacts, sensors and front key wired to the timer inputs.
   Assumes the bench picks closed contacts just after a clock edge. */
`timescale 1ns/1ps
module contact_model (
	input wire logic clk_i,
	input wire logic [3:0] press_i,
	output logic start_o = 1'b0,
	output logic reset_o = 1'b0,
	output logic gate_o = 1'b0,
	output logic key_o = 1'b0
);
	// closing lags one edge; the core still treats it as asynchronous
	always @(posedge clk_i) begin
		{key_o, gate_o, reset_o, start_o} <= press_i;
	end
endmodule : contact_model

//--- test/preset_interval_timer_io_tb.sv
/* Self-checking bench for the timer I/O core: register tasks and
   contact sequences. Assumes shortened widths, tick and flash. */
`timescale 1ns/1ps
module preset_interval_timer_io_tb;
	localparam logic [3:0] ST = 4'h1;
	localparam logic [3:0] RS = 4'h2;
	localparam logic [3:0] GT = 4'h4;
	localparam logic [3:0] KY = 4'h8;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [3:0] pins = 4'h0;
	logic [3:0] addr_i = 4'h0;
	logic [31:0] wdata_i = 32'h0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [31:0] rdata_o, p1, p2;
	logic control_out_o, reset_led_o, unit_led_o, irq_o;
	logic start_i, reset_in_i, gate_i, reset_key_i;
	int err_total = 0;
	int comparisons = 0;
	int n;
	logic seen;
	always #50 clk_i = ~clk_i;
	contact_model u_contact_model (.clk_i(clk_i), .press_i(pins),
		.start_o(start_i), .reset_o(reset_in_i), .gate_o(gate_i),
		.key_o(reset_key_i));
	preset_interval_timer_io #(.WIDTH_SHORT(4), .WIDTH_LONG(8), .TICK(4),
		.FLASH(4)) u_preset_interval_timer_io (.clk_i(clk_i), .rst_i(rst_i),
		.start_i(start_i), .reset_in_i(reset_in_i), .gate_i(gate_i),
		.reset_key_i(reset_key_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.control_out_o(control_out_o), .reset_led_o(reset_led_o),
		.unit_led_o(unit_led_o), .irq_o(irq_o));
	task hold(input int c);
		repeat (c) @(posedge clk_i);
		// look at outputs only once the edge has settled them
		#1;
	endtask : hold
	task chk(input string what, input logic [31:0] got, input logic [31:0] e);
		comparisons++;
		if (got !== e) begin
			err_total++;
			$display("FAIL %s expected %h seen %h", what, e, got);
		end
	endtask : chk
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask : wr
	task rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask : rd
	task rchk(input logic [3:0] a, input logic [31:0] e);
		rd(a, p2);
		chk($sformatf("reg %h", a), p2, e);
	endtask : rchk
	task press(input logic [3:0] m, input int c);
		pins <= m;
		hold(c);
		pins <= 4'h0;
		hold(12);
	endtask : press
	task end_sim;
		$display("errors %0d comparisons %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : end_sim
	initial begin
		hold(6000);
		err_total++;
		end_sim();
	end
	initial begin
		hold(4);
		rst_i <= 1'b0;
		hold(1);
		rchk(timer_io_pkg::REG_CONTROL, 32'h0);
		rchk(timer_io_pkg::REG_SET_VALUE, {8'h00, timer_io_pkg::SET_RESET});
		rchk(timer_io_pkg::REG_MASK, 32'h0);
		rchk(4'hF, 32'h0);
		wr(timer_io_pkg::REG_SET_VALUE, 32'h3);
		wr(timer_io_pkg::REG_MASK, 32'h1);
		press(ST, 12);
		seen = 1'b0;
		repeat (100) begin
			hold(1);
			if (control_out_o === 1'b1) seen = 1'b1;
		end
		chk("out_on", 32'(seen), 32'h1);
		chk("irq", 32'(irq_o), 32'h1);
		pins <= RS;
		n = 0;
		while (control_out_o !== 1'b0 && n < 40) begin
			hold(1);
			n++;
		end
		// sync flops blur the figure, so a band is allowed
		chk("off_delay", 32'(n >= 4 && n <= 12), 32'h1);
		hold(12);
		chk("led_on", 32'(reset_led_o), 32'h1);
		chk("out_off", 32'(control_out_o), 32'h0);
		rchk(timer_io_pkg::REG_PRESENT, 32'h0);
		pins <= 4'h0;
		hold(20);
		chk("led_off", 32'(reset_led_o), 32'h0);
		wr(timer_io_pkg::REG_EVENT, 32'h7);
		rchk(timer_io_pkg::REG_EVENT, 32'h0);
		chk("irq_clr", 32'(irq_o), 32'h0);
		wr(timer_io_pkg::REG_SET_VALUE, 32'h64);
		press(ST, 12);
		hold(8);
		pins <= GT;
		hold(16);
		rd(timer_io_pkg::REG_PRESENT, p1);
		chk("running", 32'(p1 != 32'h0), 32'h1);
		hold(40);
		rchk(timer_io_pkg::REG_PRESENT, p1);
		rchk(timer_io_pkg::REG_STATUS, 32'hA);
		pins <= GT | RS;
		hold(20);
		rchk(timer_io_pkg::REG_PRESENT, 32'h0);
		pins <= 4'h0;
		hold(20);
		wr(timer_io_pkg::REG_CONTROL, 32'h8);
		wr(timer_io_pkg::REG_SET_VALUE, 32'h5);
		press(RS, 12);
		rchk(timer_io_pkg::REG_PRESENT, 32'h5);
		wr(timer_io_pkg::REG_SET_VALUE, 32'h64);
		for (int m = 1; m < 3; m++) begin
			wr(timer_io_pkg::REG_CONTROL, 32'(m));
			press(RS, 12);
			pins <= ST;
			hold(16);
			rd(timer_io_pkg::REG_PRESENT, p1);
			hold(40);
			rchk(timer_io_pkg::REG_PRESENT, p1);
			pins <= 4'h0;
			hold(40);
			rd(timer_io_pkg::REG_PRESENT, p2);
			chk("inhibit_end", 32'(p2 > p1), 32'h1);
		end
		wr(timer_io_pkg::REG_CONTROL, 32'h5);
		press(RS, 12);
		press(ST, 12);
		hold(40);
		press(ST, 12);
		rd(timer_io_pkg::REG_PRESENT, p1);
		chk("s_ran", 32'(p1 != 32'h0), 32'h1);
		hold(40);
		rchk(timer_io_pkg::REG_PRESENT, p1);
		wr(timer_io_pkg::REG_CONTROL, 32'h10);
		press(RS, 14);
		wr(timer_io_pkg::REG_EVENT, 32'h7);
		press(RS, 6);
		rchk(timer_io_pkg::REG_EVENT, 32'h0);
		press(RS, 14);
		rchk(timer_io_pkg::REG_EVENT, 32'h2);
		wr(timer_io_pkg::REG_CONTROL, 32'h60);
		pins <= KY;
		hold(20);
		chk("key_led", 32'(reset_led_o), 32'h1);
		rchk(timer_io_pkg::REG_PRESENT, 32'h0);
		pins <= 4'h0;
		hold(20);
		press(ST, 12);
		seen = 1'b0;
		repeat (40) begin
			hold(1);
			if (unit_led_o === 1'b0) seen = 1'b1;
		end
		chk("flash", 32'(seen), 32'h1);
		wr(timer_io_pkg::REG_CONTROL, 32'h3);
		press(RS, 12);
		press(ST, 12);
		chk("interval_on", 32'(control_out_o), 32'h1);
		end_sim();
	end
endmodule : preset_interval_timer_io_tb
